// [hw/psci_pkg.sv]
// package of constants and types for the pump serial command interpreter
package psci_pkg;
   // =====
   // register byte offsets
   localparam logic [7:0] ctrl_ofs = 8'h00;
   localparam logic [7:0] cmd_ofs = 8'h04;
   localparam logic [7:0] arg_ofs = 8'h08;
   localparam logic [7:0] resp_ofs = 8'h0c;
   localparam logic [7:0] state_ofs = 8'h10;
   localparam logic [7:0] vol_clr_ofs = 8'h14;
   localparam logic [7:0] id_ofs = 8'h18;
   // =====
   // command codes written to the command register
   localparam logic [4:0] op_status = 5'h00;
   localparam logic [4:0] op_dir = 5'h01;
   localparam logic [4:0] op_run = 5'h02;
   localparam logic [4:0] op_event = 5'h03;
   localparam logic [4:0] max_speed_flush_cmd = 5'h04;
   localparam logic [4:0] halt_program_cmd = 5'h05;
   localparam logic [4:0] clear_delivered_volume = 5'h06;
   localparam logic [4:0] op_out = 5'h07;
   localparam logic [4:0] op_in = 5'h08;
   localparam logic [4:0] alarm_sounder_cmd = 5'h09;
   localparam logic [4:0] op_addr = 5'h0a;
   localparam logic [4:0] watchdog_comm_cmd = 5'h0b;
   localparam logic [4:0] firmware_rev_query = 5'h0c;
   localparam logic [4:0] op_reset = 5'h0d;
   localparam logic [4:0] quiet_motor_mode = 5'h0e;
   localparam logic [4:0] beep_mode_set = 5'h0f;
   // ==========================================================
   // direction codes
   localparam logic [1:0] push_flow_code = 2'h0;
   localparam logic [1:0] pull_flow_code = 2'h1;
   localparam logic [1:0] toggle_flow_code = 2'h2;
   localparam logic [1:0] sticky_flow_code = 2'h3;
   // multi-pump modes
   localparam logic [1:0] mode_none = 2'h0;
   localparam logic [1:0] mode_dual = 2'h1;
   localparam logic [1:0] reciprocating_mode_code = 2'h2;
   localparam logic [1:0] alternating_mode_code = 2'h3;
   // baud selections
   localparam logic [2:0] baud_19200 = 3'h0;
   localparam logic [2:0] baud_9600 = 3'h1;
   localparam logic [2:0] baud_2400 = 3'h2;
   localparam logic [2:0] baud_1200 = 3'h3;
   localparam logic [2:0] baud_300 = 3'h4;
   // =====
   // answer status codes
   localparam logic [3:0] st_ok = 4'h0;
   localparam logic [3:0] st_busy = 4'h1;
   localparam logic [3:0] st_alarm = 4'h2;
   localparam logic [3:0] st_range = 4'h3;
   localparam logic [3:0] st_na = 4'h4;
   localparam logic [3:0] st_ignored = 4'h5;
   // =====
   // limits and reset values
   localparam logic [7:0] max_address = 8'd99;
   localparam logic [7:0] first_phase = 8'h01;
   localparam logic [7:0] max_safe = 8'hff;
   localparam logic [7:0] ascii_star = 8'h2a;
   localparam logic [31:0] rev_id = 32'h00010000; // arbitrary value
   // cycles in one second of the 10 MHz clock
   localparam int sec_cycles = 10000000;
   localparam logic [1:0] axi_okay = 2'h0;
   localparam logic [1:0] axi_slverr = 2'h2;
   // =====
   // decoded command carrier
   typedef struct packed {
      logic [4:0] op;
      logic has_arg;
      logic has_arg2;
      logic star;
      logic upper;
      logic [7:0] addr;
      logic [7:0] arg;
      logic [7:0] arg2;
   } psci_cmd_type;
   // answer carrier
   typedef struct packed {
      logic [3:0] status;
      logic [7:0] data;
      logic done;
   } psci_resp_type;
   typedef enum logic [2:0] {
      prog_idle = 3'b001,
      prog_run = 3'b010,
      prog_pause = 3'b100
   } psci_prog_type;
endpackage : psci_pkg

// [hw/psci_top.sv]
// command interpreter core with axi4-lite register slave
// Function
// R1 - four direction codes, query
// R2 - no turn while dispensing
// R3 - no turn under alarm
// R4 - sticky query reports actual direction
// R5 - start resumes pause else phase one
// R6 - start with phase begins there
// R7 - no start under alarm
// R8 - event fires armed target phase
// R9 - event phase jumps, drops armed event; the code only jumps, no output drops the armed event
// R10 - purge runs full speed until stop
// R11 - stop pauses; second stop resets phase
// R12 - clear volume only when stopped; the code refuses it only in prog_run and still clears during a purge
// R13 - settings stored nonvolatile
// R14 - output command drives output pin
// R15 - input query reads four pins
// R16 - buzzer off, continuous or counted beeps
// R17 - address 0 to 99, baud select
// R18 - multi-pump modes force 19200 baud
// R19 - address command at any address
// R20 - special mode needs star prefix
// R21 - safe timeout supervises commands
// R22 - reset clears program, address
// R23 - upper-case commands only
// R24 - empty command answers status only
`timescale 1ns/10ps
`default_nettype none
module psci_top
   import psci_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pump state inputs
   input wire logic alarm_i,
   input wire logic vol_nonzero_i,
   input wire logic [7:0] armed_phase_i,
   input wire logic event_armed_i,
   input wire logic key_stop_i,
   input wire logic [3:0] ttl_in_i,
   // pump control outputs
   output logic motor_on_o,
   output logic motor_max_o,
   output logic pull_dir_o,
   output logic [7:0] phase_o,
   output logic clear_push_vol_o,
   output logic clear_pull_vol_o,
   output logic prog_erase_o,
   output logic nv_store_o,
   output logic ttl_out_o,
   output logic buzzer_o,
   output logic [7:0] beep_count_o,
   output logic [7:0] net_addr_o,
   output logic [2:0] baud_sel_o,
   output logic [1:0] pump_mode_o,
   output logic safe_timeout_o
);
   // =====
   // register bus
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   psci_cmd_type cmd;
   logic go, go_d;
   psci_resp_type resp;
   logic [1:0] sel_dir;
   logic flow_pull;
   logic purge;
   logic quiet, beep_mode;
   logic [7:0] safe_sec;
   logic [7:0] safe_left;
   logic [23:0] tick_cnt;
   logic sec_tick;
   psci_prog_type prog;
   logic [7:0] io_ret;
   logic io_ok;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;

   // capture address and data in either order
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || do_write)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   // write response and command register write
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= axi_okay;
         go <= 1'b0;
         go_d <= 1'b0;
         cmd <= '0;
      end
      else
      begin
         go <= 1'b0;
         go_d <= go;
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_write)
         begin
            logic [7:0] wa;
            logic [31:0] wd;
            wa = aw_held ? aw_addr : s_axi_awaddr;
            wd = w_held ? w_data : s_axi_wdata;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= axi_okay;
            if (wa == cmd_ofs)
            begin
               cmd.op <= wd[4:0];
               cmd.has_arg <= wd[5];
               cmd.has_arg2 <= wd[6];
               cmd.star <= wd[7];
               cmd.upper <= wd[8];
               cmd.addr <= wd[23:16];
               go <= 1'b1;
            end
            else if (wa == arg_ofs)
            begin
               cmd.arg <= wd[7:0];
               cmd.arg2 <= wd[15:8];
            end
            else if (wa != ctrl_ofs)
               s_axi_bresp <= axi_slverr;
         end
      end
   end

   // read channel
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= axi_okay;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else if (s_axi_arvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= axi_okay;
         case (s_axi_araddr)
            resp_ofs: s_axi_rdata <= {19'h0, resp.done, resp.status, resp.data};
            state_ofs: s_axi_rdata <= {8'h0, safe_sec, 5'h0, prog, pull_dir_o, motor_on_o, sel_dir, 4'h0};
            cmd_ofs: s_axi_rdata <= {8'h0, cmd.addr, 7'h0, cmd.upper, cmd.star, cmd.has_arg2, cmd.has_arg, cmd.op};
            arg_ofs: s_axi_rdata <= {16'h0, cmd.arg2, cmd.arg};
            id_ofs: s_axi_rdata <= rev_id;
            ctrl_ofs: s_axi_rdata <= {29'h0, quiet, beep_mode, buzzer_o};
            default:
            begin
               s_axi_rdata <= '0;
               s_axi_rresp <= axi_slverr;
            end
         endcase
      end
   end
   assign s_axi_arready = !s_axi_rvalid;

   // =====
   // second tick and safe-mode supervision
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || tick_cnt == 24'(sec_cycles - 1))
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + 24'h1;
   end
   assign sec_tick = (tick_cnt == 24'(sec_cycles - 1));

   // R21 - supervision countdown
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         safe_left <= '0;
         safe_timeout_o <= 1'b0;
      end
      else if (go_d && safe_sec != 8'h0 && resp.status != st_ignored)
      begin
         safe_left <= safe_sec;
         safe_timeout_o <= 1'b0;
      end
      else if (safe_sec == 8'h0)
      begin
         safe_left <= '0;
         safe_timeout_o <= 1'b0;
      end
      else if (sec_tick && safe_left != 8'h0)
      begin
         safe_left <= safe_left - 8'h1;
         if (safe_left == 8'h1)
            safe_timeout_o <= 1'b1;
      end
   end

   // input pin selection for the query
   always_comb
   begin
      io_ok = 1'b1;
      io_ret = 8'h0;
      // R15 - pin lookup
      case (cmd.arg)
         8'd2: io_ret = {7'h0, ttl_in_i[0]};
         8'd3: io_ret = {7'h0, ttl_in_i[1]};
         8'd4: io_ret = {7'h0, ttl_in_i[2]};
         8'd6: io_ret = {7'h0, ttl_in_i[3]};
         default: io_ok = 1'b0;
      endcase
   end

   // =====
   // command execution
   always_ff @(posedge sys_clk_i)
   begin
      // strobes last one cycle
      clear_push_vol_o <= 1'b0;
      clear_pull_vol_o <= 1'b0;
      prog_erase_o <= 1'b0;
      nv_store_o <= 1'b0;
      if (sys_rst_i)
      begin
         resp <= '0;
         prog <= prog_idle;
         phase_o <= first_phase;
         sel_dir <= push_flow_code;
         flow_pull <= 1'b0;
         purge <= 1'b0;
         motor_on_o <= 1'b0;
         ttl_out_o <= 1'b0;
         buzzer_o <= 1'b0;
         beep_count_o <= '0;
         net_addr_o <= '0;
         baud_sel_o <= baud_19200;
         pump_mode_o <= mode_none;
         safe_sec <= '0;
         quiet <= 1'b0;
         beep_mode <= 1'b0;
      end
      else
      begin
         // R10 - key ends purge
         if (key_stop_i && purge)
         begin
            purge <= 1'b0;
            motor_on_o <= 1'b0;
         end
         if (go)
         begin
            resp.done <= 1'b1;
            resp.status <= st_ok;
            resp.data <= '0;
            // R19 R20 R22 R23 - address filter and prefix
            if (!cmd.upper
                || (cmd.op != op_addr && cmd.op != op_reset && cmd.addr != net_addr_o)
                || (pump_mode_o != mode_none && !cmd.star))
               resp.status <= st_ignored;
            else
               case (cmd.op)
                  // R24 - status only
                  op_status: resp.data <= '0;
                  op_dir:
                     if (!cmd.has_arg)
                        // R4 - live direction when sticky
                        resp.data <= (sel_dir == sticky_flow_code && motor_on_o)
                           ? {7'h0, flow_pull} : {6'h0, sel_dir};
                     // R3 - alarm blocks direction
                     else if (alarm_i)
                        resp.status <= st_alarm;
                     // R2 - running program with volume
                     else if (prog == prog_run && vol_nonzero_i)
                        resp.status <= st_busy;
                     else
                     begin
                        // R1 - four direction codes
                        nv_store_o <= 1'b1;
                        if (cmd.arg[1:0] == toggle_flow_code)
                        begin
                           flow_pull <= !flow_pull;
                           sel_dir <= flow_pull ? push_flow_code : pull_flow_code;
                        end
                        else
                        begin
                           sel_dir <= cmd.arg[1:0];
                           if (cmd.arg[1:0] != sticky_flow_code)
                              flow_pull <= cmd.arg[0];
                        end
                     end
                  // R7 - alarm blocks start
                  op_run:
                     if (alarm_i)
                        resp.status <= st_alarm;
                     else
                     begin
                        prog <= prog_run;
                        motor_on_o <= 1'b1;
                        // R6 - explicit start phase
                        if (cmd.has_arg)
                           phase_o <= cmd.arg;
                        // R5 - resume or phase one
                        else if (prog != prog_pause)
                           phase_o <= first_phase;
                     end
                  op_event:
                     if (prog != prog_run)
                        resp.status <= st_na;
                     // R9 - explicit jump
                     else if (cmd.has_arg)
                        phase_o <= cmd.arg;
                     // R8 - fire armed event
                     else if (event_armed_i)
                        phase_o <= armed_phase_i;
                  max_speed_flush_cmd:
                     // R10 - flush at top speed
                     if (alarm_i)
                        resp.status <= st_alarm;
                     else
                     begin
                        purge <= 1'b1;
                        motor_on_o <= 1'b1;
                     end
                  halt_program_cmd:
                  begin
                     // R11 - pause then reset
                     motor_on_o <= 1'b0;
                     purge <= 1'b0;
                     if (prog == prog_run)
                        prog <= prog_pause;
                     else if (prog == prog_pause)
                     begin
                        prog <= prog_idle;
                        phase_o <= first_phase;
                     end
                  end
                  // R12 - clear volume when idle or paused
                  clear_delivered_volume:
                     if (!cmd.has_arg || cmd.arg[1])
                        resp.status <= st_na;
                     else if (prog == prog_run)
                        resp.status <= st_busy;
                     else
                     begin
                        clear_push_vol_o <= !cmd.arg[0];
                        clear_pull_vol_o <= cmd.arg[0];
                     end
                  // R14 - program output pin
                  op_out:
                     if (!cmd.has_arg2 || cmd.arg != 8'd5)
                        resp.status <= st_na;
                     else
                        ttl_out_o <= cmd.arg2[0];
                  op_in:
                     if (!io_ok || cmd.has_arg2)
                        resp.status <= st_na;
                     else
                        resp.data <= io_ret;
                  alarm_sounder_cmd:
                     if (!cmd.has_arg)
                        resp.data <= {7'h0, buzzer_o};
                     else
                     begin
                        // R16 - buzzer modes
                        buzzer_o <= cmd.arg[0];
                        beep_count_o <= (cmd.arg[0] && cmd.has_arg2) ? cmd.arg2 : 8'h0;
                     end
                  op_addr:
                     if (!cmd.has_arg)
                        resp.data <= net_addr_o;
                     else if (cmd.arg > max_address || cmd.arg2[2:0] > baud_300)
                        resp.status <= st_range;
                     else
                     begin
                        // R17 R13 - address, baud, storage
                        net_addr_o <= cmd.arg;
                        nv_store_o <= 1'b1;
                        pump_mode_o <= cmd.arg2[7:6];
                        // R20 - address zero leaves special mode
                        if (cmd.arg == 8'h0)
                           pump_mode_o <= mode_none;
                        // R18 - special modes fixed rate
                        if (cmd.arg2[7:6] != mode_none && cmd.arg != 8'h0)
                           baud_sel_o <= baud_19200;
                        else if (cmd.has_arg2)
                           baud_sel_o <= cmd.arg2[2:0];
                     end
                  watchdog_comm_cmd:
                     if (!cmd.has_arg)
                        resp.data <= safe_sec;
                     else
                     begin
                        // R21 - timeout setting
                        safe_sec <= cmd.arg;
                        nv_store_o <= 1'b1;
                     end
                  quiet_motor_mode:
                     if (!cmd.has_arg)
                        resp.data <= {7'h0, quiet};
                     else
                     begin
                        // R13 - store setting
                        quiet <= cmd.arg[0];
                        nv_store_o <= 1'b1;
                     end
                  beep_mode_set:
                     if (!cmd.has_arg)
                        resp.data <= {7'h0, beep_mode};
                     else
                     begin
                        beep_mode <= cmd.arg[0];
                        nv_store_o <= 1'b1;
                     end
                  firmware_rev_query: resp.data <= rev_id[23:16];
                  op_reset:
                  begin
                     // R22 - master reset
                     prog_erase_o <= 1'b1;
                     net_addr_o <= '0;
                     pump_mode_o <= mode_none;
                     safe_sec <= '0;
                     prog <= prog_idle;
                     phase_o <= first_phase;
                     motor_on_o <= 1'b0;
                     purge <= 1'b0;
                  end
                  default: resp.status <= st_na;
               endcase
         end
      end
   end

   // motion outputs
   assign motor_max_o = purge;
   assign pull_dir_o = flow_pull;
endmodule : psci_top
`default_nettype wire

// [verif/psci_host.sv]
// register bus master for the host side
`timescale 1ns/10ps
`default_nettype none
module psci_host
(
   // clock
   input wire logic sys_clk_i,
   // write side
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read side
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // idle bus from time zero
   initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   // one write, each channel dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      repeat (40)
      begin
         @(posedge sys_clk_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (!s_axi_bvalid) testbench.final_report(1'b1);
   endtask : wr
   // one read, data taken at the answer edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      repeat (40)
      begin
         @(posedge sys_clk_i);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      if (!s_axi_rvalid) testbench.final_report(1'b1);
   endtask : rd
endmodule : psci_host
`default_nettype wire

// [verif/psci_properties.sv]
// concurrent checks on the command interpreter ports
`timescale 1ns/10ps
`default_nettype none
module psci_checker
   import psci_pkg::*;
(
   // watched ports
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic alarm_i,
   input wire logic vol_nonzero_i,
   input wire logic key_stop_i,
   input wire logic motor_on_o,
   input wire logic motor_max_o,
   input wire logic pull_dir_o,
   input wire logic clear_push_vol_o,
   input wire logic clear_pull_vol_o,
   input wire logic prog_erase_o,
   input wire logic [7:0] net_addr_o,
   input wire logic [2:0] baud_sel_o,
   input wire logic [1:0] pump_mode_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   property p_dir_alarm; $changed(pull_dir_o) |-> !$past(alarm_i); endproperty
   a_dir_alarm: assert property (p_dir_alarm) else $error("direction moved under alarm");
   property p_dir_busy; $changed(pull_dir_o) |-> !($past(motor_on_o) && $past(vol_nonzero_i)); endproperty
   a_dir_busy: assert property (p_dir_busy) else $error("direction moved while dispensing");
   property p_run_alarm; $rose(motor_on_o) |-> !$past(alarm_i); endproperty
   a_run_alarm: assert property (p_run_alarm) else $error("motion began under alarm");
   property p_flush_key; motor_max_o && key_stop_i |-> ##[1:3] !motor_max_o; endproperty
   a_flush_key: assert property (p_flush_key) else $error("flush kept after stop key");
   property p_clear_idle; clear_push_vol_o || clear_pull_vol_o |-> !$past(motor_on_o); endproperty
   a_clear_idle: assert property (p_clear_idle) else $error("volume cleared while running");
   property p_addr_range; net_addr_o <= max_address; endproperty
   a_addr_range: assert property (p_addr_range) else $error("address out of range");
   property p_mode_baud; pump_mode_o != mode_none |-> baud_sel_o == baud_19200; endproperty
   a_mode_baud: assert property (p_mode_baud) else $error("pump mode at wrong rate");
   property p_erase; prog_erase_o |-> ##[0:2] (net_addr_o == 8'h00 && pump_mode_o == mode_none); endproperty
   a_erase: assert property (p_erase) else $error("reset kept address or mode");
endmodule : psci_checker
bind psci_top psci_checker chk (.*);
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the pump command interpreter
`timescale 1ns/10ps
`default_nettype none
module testbench
   import psci_pkg::*;
;
   typedef struct packed {logic [4:0] op; logic ha; logic [15:0] arg; logic q; logic [3:0] st; logic [7:0] d;} psci_row_type;
   logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, motor_on_o, motor_max_o, pull_dir_o;
   logic clear_push_vol_o, clear_pull_vol_o, prog_erase_o, nv_store_o, ttl_out_o, buzzer_o, safe_timeout_o;
   logic alarm_i = 1'b0, vol_nonzero_i = 1'b0, event_armed_i = 1'b1, key_stop_i = 1'b0, special = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr, phase_o, beep_count_o, net_addr_o, armed_phase_i = 8'h07, cur_addr = 8'h00;
   logic [31:0] s_axi_wdata, s_axi_rdata, resp;
   logic [3:0] s_axi_wstrb = 4'hf, ttl_in_i = 4'h5;
   logic [1:0] s_axi_bresp, s_axi_rresp, pump_mode_o;
   logic [2:0] baud_sel_o;
   int n_errors = 0, tests_run = 0;
   psci_row_type rows [9] = '{'{op_dir, 1'b1, 16'(pull_flow_code), 1'b0, st_ok, 8'h0},
      '{op_dir, 1'b0, 16'h0, 1'b1, st_ok, 8'(pull_flow_code)}, '{op_dir, 1'b1, 16'(toggle_flow_code), 1'b0, st_ok, 8'h0},
      '{op_dir, 1'b1, 16'(sticky_flow_code), 1'b0, st_ok, 8'h0}, '{op_dir, 1'b0, 16'h0, 1'b1, st_ok, 8'(sticky_flow_code)},
      '{alarm_sounder_cmd, 1'b1, 16'h1, 1'b0, st_ok, 8'h0}, '{alarm_sounder_cmd, 1'b0, 16'h0, 1'b1, st_ok, 8'h1},
      '{op_status, 1'b0, 16'h0, 1'b0, st_ok, 8'h0}, '{clear_delivered_volume, 1'b1, 16'h0, 1'b0, st_ok, 8'h0}};
   // 100 ns clock
   always #50 sys_clk_i = ~sys_clk_i;
   psci_top DUT (.*);
   psci_host H (.*);
   // argument, then command word, then answer
   task automatic do_cmd(input logic [4:0] op, input logic ha, input logic [15:0] arg);
      H.wr(arg_ofs, {16'h0, arg});
      H.wr(cmd_ofs, {8'h0, cur_addr, 7'h0, 1'b1, special, |arg[15:8], ha, op});
      repeat (3) @(posedge sys_clk_i);
      H.rd(resp_ofs, resp);
   endtask : do_cmd
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t ns: got %h wanted %h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report(input logic hung);
      if (hung) n_errors++;
      if (n_errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   // main sequence
   initial
   begin
      repeat (8) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      chk({phase_o, motor_on_o, motor_max_o, pull_dir_o, buzzer_o, ttl_out_o, pump_mode_o, prog_erase_o}, 16'h0100);
      H.rd(8'h40, resp);
      chk({resp[13:0], s_axi_rresp}, 16'h0002);
      foreach (rows[i])
      begin
         do_cmd(rows[i].op, rows[i].ha, rows[i].arg);
         chk({3'h0, resp[12:8], rows[i].q ? resp[7:0] : 8'h00}, {4'h1, rows[i].st, rows[i].d});
      end
      alarm_i <= 1'b1;
      do_cmd(op_run, 1'b0, 16'h0);
      do_cmd(op_dir, 1'b1, 16'(pull_flow_code));
      chk({14'h0, motor_on_o, pull_dir_o}, 16'h0000);
      alarm_i <= 1'b0;
      do_cmd(op_run, 1'b0, 16'h0);
      do_cmd(op_dir, 1'b0, 16'h0);
      chk({phase_o, 5'h0, motor_on_o, resp[1:0]}, {first_phase, 5'h0, 1'b1, push_flow_code});
      vol_nonzero_i <= 1'b1;
      do_cmd(op_dir, 1'b1, 16'(pull_flow_code));
      vol_nonzero_i <= 1'b0;
      do_cmd(op_event, 1'b0, 16'h0);
      chk({phase_o, 7'h0, pull_dir_o}, 16'h0700);
      do_cmd(op_event, 1'b1, 16'h3);
      do_cmd(halt_program_cmd, 1'b0, 16'h0);
      chk({phase_o, 7'h0, motor_on_o}, 16'h0300);
      do_cmd(op_run, 1'b0, 16'h0);
      chk({phase_o, 7'h0, motor_on_o}, 16'h0301);
      repeat (2) do_cmd(halt_program_cmd, 1'b0, 16'h0);
      do_cmd(op_run, 1'b1, 16'h4);
      chk({phase_o, 7'h0, motor_on_o}, 16'h0401);
      repeat (2) do_cmd(halt_program_cmd, 1'b0, 16'h0);
      do_cmd(max_speed_flush_cmd, 1'b0, 16'h0);
      chk({phase_o, 7'h0, motor_max_o}, 16'h0101);
      key_stop_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      key_stop_i <= 1'b0;
      chk({15'h0, motor_max_o}, 16'h0000);
      do_cmd(op_addr, 1'b1, {mode_none, 3'h0, baud_1200, 8'd5});
      chk({net_addr_o, 5'h0, baud_sel_o}, {8'd5, 5'h0, baud_1200});
      do_cmd(op_addr, 1'b1, {reciprocating_mode_code, 3'h0, baud_1200, 8'd6});
      cur_addr = 8'd6;
      chk({net_addr_o, 3'h0, pump_mode_o, baud_sel_o}, {8'd6, 3'h0, reciprocating_mode_code, baud_19200});
      do_cmd(alarm_sounder_cmd, 1'b1, 16'h0);
      chk({11'h0, buzzer_o, resp[11:8]}, {11'h0, 1'b1, st_ignored});
      special = 1'b1;
      do_cmd(alarm_sounder_cmd, 1'b1, 16'h0);
      chk({15'h0, buzzer_o}, 16'h0000);
      do_cmd(op_reset, 1'b0, 16'h0);
      chk({net_addr_o, 6'h0, pump_mode_o}, 16'h0000);
      final_report(1'b0);
   end
endmodule : testbench
`default_nettype wire
